// file: include/pimb_consts.svh
// Offsets, field positions and reset masks of the interrupt mask bank.
// Assumes an 8-bit register address space and 8-bit register data.
`ifndef PIMB_CONSTS_SVH
`define PIMB_CONSTS_SVH

`define PIMB_OFF_TOP1      8'h29
`define PIMB_OFF_TOP2      8'h2a
`define PIMB_OFF_CONV      8'h2b
`define PIMB_OFF_STEPUP    8'h2c
`define PIMB_OFF_FLAG_TOP1 8'h30
`define PIMB_OFF_FLAG_TOP2 8'h31
`define PIMB_OFF_FLAG_CONV 8'h32
`define PIMB_OFF_FLAG_SP   8'h33
`define PIMB_OFF_RAW_CONV  8'h34
`define PIMB_OFF_RAW_MISC  8'h35

`define PIMB_NUM_EVT 10

`define PIMB_BIT_MEAS    7
`define PIMB_BIT_CLK     3
`define PIMB_BIT_THERM   1
`define PIMB_BIT_REGRST  0
`define PIMB_BIT_B_PGF   7
`define PIMB_BIT_B_PGR   6
`define PIMB_BIT_B_ILIM  4
`define PIMB_BIT_A_PGF   3
`define PIMB_BIT_A_PGR   2
`define PIMB_BIT_A_ILIM  0
`define PIMB_BIT_SP_PGF  3
`define PIMB_BIT_SP_PGR  2
`define PIMB_BIT_SP_ILIM 0
`define PIMB_BIT_RAW_THERM 4

`define PIMB_KEEP_TOP1   8'h8a
`define PIMB_KEEP_TOP2   8'h01
`define PIMB_KEEP_CONV   8'hdd
`define PIMB_KEEP_STEPUP 8'h0d

`endif

// file: include/pimb_evt_if.sv
// Synchronised event levels and their edges, from the event source to the mask bank.
// Assumes both ends run on mclk.
`timescale 1ns/1ps
`default_nettype none
interface pimb_evt_if #(parameter int N = 10);
    logic [N-1:0] raw;
    logic [N-1:0] rise;
    logic [N-1:0] fall;
    modport src (output raw, output rise, output fall);
    modport dst (input raw, input rise, input fall);
endinterface
`default_nettype wire

// file: include/pimb_pkg.sv
// Types shared by the interrupt mask bank modules.
// Assumes the constants header is compiled alongside.
package pimb_pkg;
    typedef logic [7:0] pimb_byte_t;
    typedef enum logic [3:0] {
        PIMB_EV_MEAS    = 4'h0,
        PIMB_EV_CLK     = 4'h1,
        PIMB_EV_THERM   = 4'h2,
        PIMB_EV_REGRST  = 4'h3,
        PIMB_EV_A_PG    = 4'h4,
        PIMB_EV_A_ILIM  = 4'h5,
        PIMB_EV_B_PG    = 4'h6,
        PIMB_EV_B_ILIM  = 4'h7,
        PIMB_EV_SP_PG   = 4'h8,
        PIMB_EV_SP_ILIM = 4'h9
    } pimb_evt_t;
endpackage

// file: logic/pimb_event_src.sv
// Two-flop synchronisers and edge detection for the monitored event levels.
// Assumes the inputs are asynchronous levels from the analog monitors.
`timescale 1ns/1ps
`default_nettype none
module pimb_event_src #(
    parameter int N = 10
) (
    // Clock and reset.
    input  wire logic         mclk,
    input  wire logic         srst,
    // Asynchronous monitor levels.
    input  wire logic [N-1:0] mon_level,
    // Synchronised levels and edges.
    pimb_evt_if.src           evt
);
    logic [N-1:0] meta;
    logic [N-1:0] sync;
    logic [N-1:0] prev;

    always_ff @(posedge mclk) begin
        if (srst) begin
            meta <= '0;
            sync <= '0;
            prev <= '0;
        end else begin
            meta <= mon_level;
            sync <= meta;
            prev <= sync;
        end
    end

    assign evt.raw  = sync;
    assign evt.rise = sync & ~prev;
    assign evt.fall = ~sync & prev;
endmodule
`default_nettype wire

// file: logic/pimb_flag_bank.sv
// Sticky interrupt flags: a set pulse holds a bit until it is cleared.
// Assumes set and clear come from logic on mclk.
`timescale 1ns/1ps
`default_nettype none
module pimb_flag_bank #(
    parameter int W = 32
) (
    // Clock and reset.
    input  wire logic         mclk,
    input  wire logic         srst,
    // Set and clear requests.
    input  wire logic [W-1:0] set_pulse,
    input  wire logic [W-1:0] clr,
    // Held flags.
    output var  logic [W-1:0] flags
);
    // A set in the clearing cycle wins, so no event is lost to a read.
    always_ff @(posedge mclk) begin
        if (srst) begin
            flags <= '0;
        end else begin
            flags <= (flags & ~clr) | set_pulse;
        end
    end
endmodule
`default_nettype wire

// file: logic/pimb_mask_bank.sv
// Interrupt mask registers, sticky flags and interrupt output of the power manager.
// Assumes a same-clock register port and static one-time-programmable defaults.
//
// What this block does
// - Top mask bit 7 set suppresses the measurement-ready flag; clear lets it set.
// - Top mask bit 3 set suppresses the external clock detection flag.
// - Top mask bit 1 gates the thermal warning flag; raw thermal status stays live.
// - Second top mask bit 0 gates the register-reset flag; reset loads it from otp_mask_default bit 8.
// - Converter mask bit 7 set blocks converter B power-good flag on fall.
// - Converter mask bit 6 set blocks converter B power-good flag on rise.
// - Converter mask bit 4 gates converter B current-limit flag; raw unaffected.
// - Converter mask bit 3 set blocks converter A power-good flag on fall.
// - Converter mask bit 2 set blocks converter A power-good flag on rise.
// - Converter mask bit 0 gates converter A current-limit flag; raw unaffected.
// - Raw power-good bits follow output validity whatever the masks hold.
// - Every implemented mask bit loads its programmed default at reset; reserved bits load zero.
// - Step-up mask bits 3 and 2 block its power-good flag on fall and rise.
// - Step-up mask bit 0 gates its current-limit flag; raw unaffected.
`timescale 1ns/1ps
`default_nettype none
`include "pimb_consts.svh"
module pimb_mask_bank
    import pimb_pkg::*;
(
    // Clock and reset.
    input  wire logic       mclk,
    input  wire logic       srst,
    // Programmed mask defaults: top1, top2, converter, step-up from low byte up.
    input  wire logic [31:0] otp_mask_default,
    // Asynchronous monitor levels, indexed by pimb_evt_t.
    input  wire logic [`PIMB_NUM_EVT-1:0] mon_level,
    // Register port.
    input  wire logic [7:0] rg_addr,
    input  wire logic [7:0] rg_wdata,
    input  wire logic       rg_wr,
    input  wire logic       rg_rd,
    output var  logic [7:0] rg_rdata,
    // Interrupt.
    output var  logic       irq
);
    pimb_byte_t  top_mask_first;
    pimb_byte_t  top_mask_second;
    pimb_byte_t  converter_mask;
    pimb_byte_t  step_up_mask;
    pimb_byte_t  set_top1;
    pimb_byte_t  set_top2;
    pimb_byte_t  set_conv;
    pimb_byte_t  set_sp;
    pimb_byte_t  raw_conv;
    pimb_byte_t  raw_misc;
    logic [31:0] flag_set;
    logic [31:0] flag_clr;
    logic [31:0] flags;
    pimb_byte_t  flag_top1;
    pimb_byte_t  flag_top2;
    pimb_byte_t  flag_conv;
    pimb_byte_t  flag_sp;

    pimb_evt_if #(.N(`PIMB_NUM_EVT)) evt ();

    pimb_event_src #(.N(`PIMB_NUM_EVT)) u_src (
        .mclk      (mclk),
        .srst      (srst),
        .mon_level (mon_level),
        .evt       (evt.src)
    );

    pimb_flag_bank #(.W(32)) u_flags (
        .mclk      (mclk),
        .srst      (srst),
        .set_pulse (flag_set),
        .clr       (flag_clr),
        .flags     (flags)
    );

    assign flag_top1 = flags[7:0];
    assign flag_top2 = flags[15:8];
    assign flag_conv = flags[23:16];
    assign flag_sp   = flags[31:24];

    // Reserved bits are cleared at reset even if the programmed word has them set.
    always_ff @(posedge mclk) begin
        if (srst) begin
            top_mask_first <= otp_mask_default[7:0] & `PIMB_KEEP_TOP1;
        end else if (rg_wr && rg_addr == `PIMB_OFF_TOP1) begin
            top_mask_first <= rg_wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            top_mask_second <= otp_mask_default[15:8] & `PIMB_KEEP_TOP2;
        end else if (rg_wr && rg_addr == `PIMB_OFF_TOP2) begin
            top_mask_second <= rg_wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            converter_mask <= otp_mask_default[23:16] & `PIMB_KEEP_CONV;
        end else if (rg_wr && rg_addr == `PIMB_OFF_CONV) begin
            converter_mask <= rg_wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            step_up_mask <= otp_mask_default[31:24] & `PIMB_KEEP_STEPUP;
        end else if (rg_wr && rg_addr == `PIMB_OFF_STEPUP) begin
            step_up_mask <= rg_wdata;
        end
    end

    // Power-good flag for one converter: either edge, each with its own mask.
    function automatic logic pg_event(input logic rise, input logic fall,
                                      input logic rise_mask, input logic fall_mask);
        pg_event = (rise && !rise_mask) || (fall && !fall_mask);
    endfunction

    // Masks are sampled at the event only; flags are never cleared by a mask.
    always_comb begin
        set_top1 = 8'h00;
        set_top2 = 8'h00;
        set_conv = 8'h00;
        set_sp   = 8'h00;
        set_top1[`PIMB_BIT_MEAS]   = evt.rise[PIMB_EV_MEAS]
                                     && !top_mask_first[`PIMB_BIT_MEAS];
        set_top1[`PIMB_BIT_CLK]    = evt.rise[PIMB_EV_CLK]
                                     && !top_mask_first[`PIMB_BIT_CLK];
        set_top1[`PIMB_BIT_THERM]  = evt.rise[PIMB_EV_THERM]
                                     && !top_mask_first[`PIMB_BIT_THERM];
        set_top2[`PIMB_BIT_REGRST] = evt.rise[PIMB_EV_REGRST]
                                     && !top_mask_second[`PIMB_BIT_REGRST];
        set_conv[`PIMB_BIT_B_PGR]  = pg_event(evt.rise[PIMB_EV_B_PG], evt.fall[PIMB_EV_B_PG],
                                              converter_mask[`PIMB_BIT_B_PGR],
                                              converter_mask[`PIMB_BIT_B_PGF]);
        set_conv[`PIMB_BIT_B_ILIM] = evt.rise[PIMB_EV_B_ILIM]
                                     && !converter_mask[`PIMB_BIT_B_ILIM];
        set_conv[`PIMB_BIT_A_PGR]  = pg_event(evt.rise[PIMB_EV_A_PG], evt.fall[PIMB_EV_A_PG],
                                              converter_mask[`PIMB_BIT_A_PGR],
                                              converter_mask[`PIMB_BIT_A_PGF]);
        set_conv[`PIMB_BIT_A_ILIM] = evt.rise[PIMB_EV_A_ILIM]
                                     && !converter_mask[`PIMB_BIT_A_ILIM];
        set_sp[`PIMB_BIT_SP_PGR]   = pg_event(evt.rise[PIMB_EV_SP_PG], evt.fall[PIMB_EV_SP_PG],
                                              step_up_mask[`PIMB_BIT_SP_PGR],
                                              step_up_mask[`PIMB_BIT_SP_PGF]);
        set_sp[`PIMB_BIT_SP_ILIM]  = evt.rise[PIMB_EV_SP_ILIM]
                                     && !step_up_mask[`PIMB_BIT_SP_ILIM];
        flag_set = {set_sp, set_conv, set_top2, set_top1};
    end

    // Raw status bits come straight from the synchronisers, ignoring every mask.
    always_comb begin
        raw_conv = 8'h00;
        raw_misc = 8'h00;
        raw_conv[`PIMB_BIT_B_PGR]      = evt.raw[PIMB_EV_B_PG];
        raw_conv[`PIMB_BIT_B_ILIM]     = evt.raw[PIMB_EV_B_ILIM];
        raw_conv[`PIMB_BIT_A_PGR]      = evt.raw[PIMB_EV_A_PG];
        raw_conv[`PIMB_BIT_A_ILIM]     = evt.raw[PIMB_EV_A_ILIM];
        raw_misc[`PIMB_BIT_RAW_THERM]  = evt.raw[PIMB_EV_THERM];
        raw_misc[`PIMB_BIT_SP_PGR]     = evt.raw[PIMB_EV_SP_PG];
        raw_misc[`PIMB_BIT_SP_ILIM]    = evt.raw[PIMB_EV_SP_ILIM];
    end

    // Reading a flag register clears the bits it returned.
    always_comb begin
        flag_clr = 32'h0;
        if (rg_rd) begin
            case (rg_addr)
                `PIMB_OFF_FLAG_TOP1: flag_clr[7:0]   = 8'hff;
                `PIMB_OFF_FLAG_TOP2: flag_clr[15:8]  = 8'hff;
                `PIMB_OFF_FLAG_CONV: flag_clr[23:16] = 8'hff;
                `PIMB_OFF_FLAG_SP:   flag_clr[31:24] = 8'hff;
                default:             flag_clr        = 32'h0;
            endcase
        end
    end

    function automatic pimb_byte_t read_mux(input logic [7:0] addr);
        case (addr)
            `PIMB_OFF_TOP1:      read_mux = top_mask_first;
            `PIMB_OFF_TOP2:      read_mux = top_mask_second;
            `PIMB_OFF_CONV:      read_mux = converter_mask;
            `PIMB_OFF_STEPUP:    read_mux = step_up_mask;
            `PIMB_OFF_FLAG_TOP1: read_mux = flag_top1;
            `PIMB_OFF_FLAG_TOP2: read_mux = flag_top2;
            `PIMB_OFF_FLAG_CONV: read_mux = flag_conv;
            `PIMB_OFF_FLAG_SP:   read_mux = flag_sp;
            `PIMB_OFF_RAW_CONV:  read_mux = raw_conv;
            `PIMB_OFF_RAW_MISC:  read_mux = raw_misc;
            default:             read_mux = 8'h00;
        endcase
    endfunction

    // Read data stand only in the cycle after the strobe, zero otherwise.
    always_ff @(posedge mclk) begin
        if (srst) begin
            rg_rdata <= 8'h00;
        end else if (rg_rd) begin
            rg_rdata <= read_mux(rg_addr);
        end else begin
            rg_rdata <= 8'h00;
        end
    end

    // Only unmasked events ever become flags, so any flag raises the line.
    always_ff @(posedge mclk) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= |flags;
        end
    end

    meas_masked_a: assert property (@(posedge mclk) disable iff (srst)
        evt.rise[PIMB_EV_MEAS] && top_mask_first[`PIMB_BIT_MEAS] && !flag_top1[`PIMB_BIT_MEAS]
        |=> !flag_top1[`PIMB_BIT_MEAS])
        else $error("masked measurement event set its flag");

    meas_set_a: assert property (@(posedge mclk) disable iff (srst)
        evt.rise[PIMB_EV_MEAS] && !top_mask_first[`PIMB_BIT_MEAS]
        |=> flag_top1[`PIMB_BIT_MEAS] ##1 irq)
        else $error("unmasked measurement event lost");

    clk_detect_a: assert property (@(posedge mclk) disable iff (srst)
        evt.rise[PIMB_EV_CLK] |=> flag_top1[`PIMB_BIT_CLK] == !$past(top_mask_first[3])
                                  || $past(flag_top1[`PIMB_BIT_CLK]))
        else $error("clock detection flag disagrees with mask");

    therm_raw_a: assert property (@(posedge mclk) disable iff (srst)
        rg_rd && rg_addr == `PIMB_OFF_RAW_MISC
        |=> rg_rdata[`PIMB_BIT_RAW_THERM] == $past(evt.raw[PIMB_EV_THERM]))
        else $error("raw thermal status not shown");

    regrst_mask_a: assert property (@(posedge mclk)
        srst ##1 !srst |-> top_mask_second == ($past(otp_mask_default[15:8]) & 8'h01))
        else $error("second top mask reset value wrong");

    b_pg_fall_a: assert property (@(posedge mclk) disable iff (srst)
        evt.fall[PIMB_EV_B_PG] && converter_mask[7] && !flag_conv[`PIMB_BIT_B_PGR]
        |=> !flag_conv[`PIMB_BIT_B_PGR])
        else $error("masked converter B fall raised a flag");

    b_pg_rise_a: assert property (@(posedge mclk) disable iff (srst)
        evt.rise[PIMB_EV_B_PG] && !converter_mask[6] |=> flag_conv[`PIMB_BIT_B_PGR])
        else $error("converter B rise flag not raised");

    b_ilim_a: assert property (@(posedge mclk) disable iff (srst)
        evt.rise[PIMB_EV_B_ILIM] && !converter_mask[4] |=> flag_conv[`PIMB_BIT_B_ILIM])
        else $error("converter B current-limit flag not raised");

    a_pg_fall_a: assert property (@(posedge mclk) disable iff (srst)
        evt.fall[PIMB_EV_A_PG] && !converter_mask[3] |=> flag_conv[`PIMB_BIT_A_PGR])
        else $error("converter A fall flag not raised");

    a_pg_rise_a: assert property (@(posedge mclk) disable iff (srst)
        evt.rise[PIMB_EV_A_PG] && converter_mask[2] && !flag_conv[`PIMB_BIT_A_PGR]
        |=> !flag_conv[`PIMB_BIT_A_PGR])
        else $error("masked converter A rise raised a flag");

    a_ilim_a: assert property (@(posedge mclk) disable iff (srst)
        evt.rise[PIMB_EV_A_ILIM] && converter_mask[0] && !flag_conv[`PIMB_BIT_A_ILIM]
        |=> !flag_conv[`PIMB_BIT_A_ILIM])
        else $error("masked converter A current limit raised a flag");

    pg_raw_a: assert property (@(posedge mclk) disable iff (srst)
        rg_rd && rg_addr == `PIMB_OFF_RAW_CONV
        |=> rg_rdata[`PIMB_BIT_A_PGR] == $past(evt.raw[PIMB_EV_A_PG])
            && rg_rdata[`PIMB_BIT_B_PGR] == $past(evt.raw[PIMB_EV_B_PG]))
        else $error("raw power-good status not shown");

    conv_reset_a: assert property (@(posedge mclk)
        srst ##1 !srst |-> converter_mask == ($past(otp_mask_default[23:16]) & 8'hdd))
        else $error("converter mask did not load its default");

    top_reserved_a: assert property (@(posedge mclk)
        srst ##1 !srst |-> (top_mask_first & 8'h75) == 8'h00)
        else $error("reserved top mask bits not zero after reset");

    sp_pg_a: assert property (@(posedge mclk) disable iff (srst)
        (evt.rise[PIMB_EV_SP_PG] && !step_up_mask[2]) || (evt.fall[PIMB_EV_SP_PG]
        && !step_up_mask[3]) |=> flag_sp[`PIMB_BIT_SP_PGR])
        else $error("step-up power-good flag not raised");

    sp_ilim_a: assert property (@(posedge mclk) disable iff (srst)
        evt.rise[PIMB_EV_SP_ILIM] && !step_up_mask[0] |=> flag_sp[`PIMB_BIT_SP_ILIM])
        else $error("step-up current-limit flag not raised");

    pending_kept_a: assert property (@(posedge mclk) disable iff (srst)
        flag_top1[`PIMB_BIT_MEAS] && !(rg_rd && rg_addr == `PIMB_OFF_FLAG_TOP1)
        |=> flag_top1[`PIMB_BIT_MEAS])
        else $error("pending flag lost without a read");

    irq_follow_a: assert property (@(posedge mclk) disable iff (srst)
        ##1 irq == $past(|flags))
        else $error("interrupt line does not follow the flags");

    therm_masked_a: assert property (@(posedge mclk) disable iff (srst)
        evt.rise[PIMB_EV_THERM] && top_mask_first[`PIMB_BIT_THERM]
        && !flag_top1[`PIMB_BIT_THERM] |=> !flag_top1[`PIMB_BIT_THERM])
        else $error("masked thermal warning set its flag");

    therm_set_a: assert property (@(posedge mclk) disable iff (srst)
        evt.rise[PIMB_EV_THERM] && !top_mask_first[`PIMB_BIT_THERM]
        |=> flag_top1[`PIMB_BIT_THERM])
        else $error("unmasked thermal warning lost");

    regrst_set_a: assert property (@(posedge mclk) disable iff (srst)
        evt.rise[PIMB_EV_REGRST] && !top_mask_second[`PIMB_BIT_REGRST]
        |=> flag_top2[`PIMB_BIT_REGRST])
        else $error("unmasked register reset event lost");

    regrst_masked_a: assert property (@(posedge mclk) disable iff (srst)
        evt.rise[PIMB_EV_REGRST] && top_mask_second[`PIMB_BIT_REGRST]
        && !flag_top2[`PIMB_BIT_REGRST] |=> !flag_top2[`PIMB_BIT_REGRST])
        else $error("masked register reset event set its flag");

    b_fall_set_a: assert property (@(posedge mclk) disable iff (srst)
        evt.fall[PIMB_EV_B_PG] && !converter_mask[`PIMB_BIT_B_PGF]
        |=> flag_conv[`PIMB_BIT_B_PGR])
        else $error("converter B fall flag not raised");

    b_rise_masked_a: assert property (@(posedge mclk) disable iff (srst)
        evt.rise[PIMB_EV_B_PG] && converter_mask[`PIMB_BIT_B_PGR]
        && !flag_conv[`PIMB_BIT_B_PGR] |=> !flag_conv[`PIMB_BIT_B_PGR])
        else $error("masked converter B rise raised a flag");

    b_ilim_masked_a: assert property (@(posedge mclk) disable iff (srst)
        evt.rise[PIMB_EV_B_ILIM] && converter_mask[`PIMB_BIT_B_ILIM]
        && !flag_conv[`PIMB_BIT_B_ILIM] |=> !flag_conv[`PIMB_BIT_B_ILIM])
        else $error("masked converter B current limit raised a flag");

    a_fall_masked_a: assert property (@(posedge mclk) disable iff (srst)
        evt.fall[PIMB_EV_A_PG] && converter_mask[`PIMB_BIT_A_PGF]
        && !flag_conv[`PIMB_BIT_A_PGR] |=> !flag_conv[`PIMB_BIT_A_PGR])
        else $error("masked converter A fall raised a flag");

    a_rise_set_a: assert property (@(posedge mclk) disable iff (srst)
        evt.rise[PIMB_EV_A_PG] && !converter_mask[`PIMB_BIT_A_PGR]
        |=> flag_conv[`PIMB_BIT_A_PGR])
        else $error("converter A rise flag not raised");

    sp_pg_masked_a: assert property (@(posedge mclk) disable iff (srst)
        ((evt.rise[PIMB_EV_SP_PG] && step_up_mask[`PIMB_BIT_SP_PGR])
        || (evt.fall[PIMB_EV_SP_PG] && step_up_mask[`PIMB_BIT_SP_PGF]))
        && !flag_sp[`PIMB_BIT_SP_PGR] |=> !flag_sp[`PIMB_BIT_SP_PGR])
        else $error("masked step-up power-good edge raised a flag");

    sp_ilim_masked_a: assert property (@(posedge mclk) disable iff (srst)
        evt.rise[PIMB_EV_SP_ILIM] && step_up_mask[`PIMB_BIT_SP_ILIM]
        && !flag_sp[`PIMB_BIT_SP_ILIM] |=> !flag_sp[`PIMB_BIT_SP_ILIM])
        else $error("masked step-up current limit raised a flag");
endmodule
`default_nettype wire

// file: test/test_pimb_mask_bank.sv
// Self-checking bench for the interrupt mask bank: mask registers, flags, raw status, irq.
// Assumes the design files, the package and the constants header are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "pimb_consts.svh"
module test_pimb_mask_bank
    import pimb_pkg::*;
;
    logic                     mclk;
    logic                     srst;
    logic [31:0]              otp_mask_default;
    logic [`PIMB_NUM_EVT-1:0] mon_level;
    pimb_byte_t               rg_addr;
    pimb_byte_t               rg_wdata;
    logic                     rg_wr;
    logic                     rg_rd;
    pimb_byte_t               rg_rdata;
    logic                     irq;
    int                       fails;
    int                       check_count;
    int                       seed_val;
    pimb_byte_t               model [4];
    pimb_byte_t               offs  [4] = '{8'h29, 8'h2a, 8'h2b, 8'h2c};
    pimb_byte_t               keep  [4] = '{`PIMB_KEEP_TOP1, `PIMB_KEEP_TOP2,
                                            `PIMB_KEEP_CONV, `PIMB_KEEP_STEPUP};
    // One row per event test; power-good appears twice, once per edge direction.
    int         ev_idx  [13] = '{0, 1, 2, 3, 4, 4, 5, 6, 6, 7, 8, 8, 9};
    pimb_byte_t ev_moff [13] = '{8'h29, 8'h29, 8'h29, 8'h2a, 8'h2b, 8'h2b, 8'h2b,
                                 8'h2b, 8'h2b, 8'h2b, 8'h2c, 8'h2c, 8'h2c};
    int         ev_mbit [13] = '{7, 3, 1, 0, 2, 3, 0, 6, 7, 4, 2, 3, 0};
    pimb_byte_t ev_foff [13] = '{8'h30, 8'h30, 8'h30, 8'h31, 8'h32, 8'h32, 8'h32,
                                 8'h32, 8'h32, 8'h32, 8'h33, 8'h33, 8'h33};
    int         ev_fbit [13] = '{7, 3, 1, 0, 2, 2, 0, 6, 6, 4, 2, 2, 0};
    bit         ev_fall [13] = '{0, 0, 0, 0, 0, 1, 0, 0, 1, 0, 0, 1, 0};
    pimb_byte_t ev_roff [13] = '{8'h00, 8'h00, 8'h35, 8'h00, 8'h34, 8'h34, 8'h34,
                                 8'h34, 8'h34, 8'h34, 8'h35, 8'h35, 8'h35};
    int         ev_rbit [13] = '{0, 0, 4, 0, 2, 2, 0, 6, 6, 4, 2, 2, 0};

    pimb_mask_bank u_pimb_mask_bank (
        .mclk             (mclk),
        .srst             (srst),
        .otp_mask_default (otp_mask_default),
        .mon_level        (mon_level),
        .rg_addr          (rg_addr),
        .rg_wdata         (rg_wdata),
        .rg_wr            (rg_wr),
        .rg_rd            (rg_rd),
        .rg_rdata         (rg_rdata),
        .irq              (irq)
    );

    always #10 mclk = ~mclk;

    function automatic pimb_byte_t reset_exp(input logic [31:0] otp, input int r);
        return otp[r*8 +: 8] & keep[r];
    endfunction

    function automatic pimb_byte_t flag_exp(input bit m, input int b);
        return m ? 8'h00 : (8'h01 << b);
    endfunction

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string name, input pimb_byte_t exp, input pimb_byte_t got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input pimb_byte_t a, input pimb_byte_t d);
        @(posedge mclk);
        rg_addr <= a;
        rg_wdata <= d;
        rg_wr <= 1'b1;
        @(posedge mclk);
        rg_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe, so it is taken mid-cycle.
    task automatic rd(input pimb_byte_t a, output pimb_byte_t d);
        @(posedge mclk);
        rg_addr <= a;
        rg_rd <= 1'b1;
        @(posedge mclk);
        rg_rd <= 1'b0;
        @(negedge mclk);
        d = rg_rdata;
    endtask

    task automatic rd_chk(input string name, input pimb_byte_t a, input pimb_byte_t exp);
        pimb_byte_t v;
        rd(a, v);
        chk(name, exp, v);
    endtask

    task automatic do_reset(input logic [31:0] otp);
        @(posedge mclk);
        srst <= 1'b1;
        otp_mask_default <= otp;
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        @(negedge mclk);
        chk("irq after reset", 8'h00, {7'h0, irq});
        for (int r = 0; r < 4; r++) begin
            model[r] = reset_exp(otp, r);
            rd_chk("mask reset value", offs[r], model[r]);
        end
    endtask

    // The level is first moved with the mask closed so only the tested edge counts.
    task automatic run_event(input int e, input bit m);
        pimb_byte_t v;
        wr(ev_moff[e], 8'hff);
        @(posedge mclk);
        mon_level[ev_idx[e]] <= ev_fall[e];
        repeat (6) @(posedge mclk);
        rd(ev_foff[e], v);
        wr(ev_moff[e], m ? 8'hff : ~(8'h01 << ev_mbit[e]));
        @(posedge mclk);
        mon_level[ev_idx[e]] <= ~ev_fall[e];
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        chk("irq on event", {7'h0, ~m}, {7'h0, irq});
        if (ev_roff[e] != 8'h00) begin
            rd(ev_roff[e], v);
            chk("raw status", {7'h0, ~ev_fall[e]}, (v >> ev_rbit[e]) & 8'h01);
        end
        if (!m) begin
            wr(ev_moff[e], 8'hff);
            @(negedge mclk);
            chk("irq kept after mask", 8'h01, {7'h0, irq});
        end
        rd(ev_foff[e], v);
        chk("flag register", flag_exp(m, ev_fbit[e]), v);
        rd_chk("flag cleared", ev_foff[e], 8'h00);
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        chk("irq cleared", 8'h00, {7'h0, irq});
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        $display("watchdog expired");
        print_verdict();
    end

    initial begin
        int         r;
        pimb_byte_t d;
        mclk = 1'b0;
        srst = 1'b1;
        otp_mask_default = 32'h0000_0000;
        mon_level = '0;
        rg_addr = 8'h00;
        rg_wdata = 8'h00;
        rg_wr = 1'b0;
        rg_rd = 1'b0;
        fails = 0;
        check_count = 0;
        seed_val = $urandom(32'h494d);
        do_reset($urandom | 32'h0000_0100);
        $display("test reset defaults done");
        for (int i = 0; i < 12; i++) begin
            r = $urandom_range(3, 0);
            d = 8'($urandom);
            wr(offs[r], d);
            model[r] = d;
        end
        wr(8'h29, 8'h75);
        model[0] = 8'h75;
        for (int k = 0; k < 4; k++) begin
            rd_chk("mask readback", offs[k], model[k]);
        end
        $display("test mask read write done");
        wr(8'h2f, 8'h5a);
        wr(8'h30, 8'hff);
        rd_chk("unmapped read", 8'h2f, 8'h00);
        rd_chk("flag read only", 8'h30, 8'h00);
        for (int k = 0; k < 4; k++) begin
            rd_chk("mask untouched", offs[k], model[k]);
        end
        $display("test unmapped access done");
        for (int e = 0; e < 13; e++) begin
            run_event(e, 1'b1);
            run_event(e, 1'b0);
        end
        $display("test event masking done");
        do_reset(32'hffff_ffff);
        $display("test second reset done");
        print_verdict();
    end
endmodule
`default_nettype wire
